// ---- hdl/bsc_pkg.sv ----
package bsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets, byte addresses in configuration space
    localparam logic [7:0] CAP_HDR_OFFSET  = 8'h74;
    localparam logic [7:0] CTRL_OFFSET     = 8'h78;

    // capability header fields and values after reset
    localparam int         HDR_ID_LSB      = 0;
    localparam int         HDR_NEXT_LSB    = 8;
    localparam int         HDR_LEN_LSB     = 16;
    localparam int         HDR_TYPE_LSB    = 24;
    localparam logic [7:0] HDR_ID_RST      = 8'h09;
    localparam logic [7:0] HDR_NEXT_RST    = 8'hb4;
    localparam logic [7:0] HDR_LEN_RST     = 8'h40;
    localparam logic [7:0] HDR_TYPE_RST    = 8'h01;

    // control byte field positions
    localparam int         CTL_MODE_LSB    = 0;
    localparam int         CTL_GUARD_BIT   = 2;
    localparam int         CTL_ACT_EN_BIT  = 3;
    localparam int         CTL_RAS_BIT     = 4;
    localparam int         CTL_PIN_PROP_BIT = 5;
    localparam int         CTL_RST_BIT     = 7;

    // far side mode encodings
    typedef enum logic [1:0] {
        BSC_ENABLED   = 2'b00,
        BSC_NOT_READY = 2'b01,
        BSC_DISABLED  = 2'b10,
        BSC_RESERVED  = 2'b11
    } bsc_mode_type;

    // values after reset of the control fields
    localparam bsc_mode_type MODE_RST_EXTERNAL = BSC_ENABLED;
    localparam bsc_mode_type MODE_RST_INTERNAL = BSC_NOT_READY;
    localparam logic         CTL_BIT_RST       = 1'b0;
    localparam logic         PIN_IDLE_LEVEL    = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration or bar4 request and its completion
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        far_side;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } bsc_cfg_req_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } bsc_cfg_rsp_type;

    // transaction arriving on the far side and its disposition
    typedef struct packed {
        logic valid;
        logic is_cfg;
    } bsc_tlp_in_type;

    typedef struct packed {
        logic accept;
        logic retry;
        logic discard;
        logic credit;
    } bsc_tlp_out_type;

    // true when a side's mode is anything other than enabled, reserved included
    function automatic logic mode_busy(input bsc_mode_type m);
        return (m != BSC_ENABLED);
    endfunction

endpackage

// ---- hdl/bsc_sync.sv ----
module bsc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    import bsc_pkg::*;

    typedef struct packed {
        logic first;
        logic second;
    } bsc_sync_state_type;

    bsc_sync_state_type s_q;
    bsc_sync_state_type s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // two flops, the first read only by the second
    always_comb begin
        s_d        = s_q;
        s_d.first  = async_i;
        s_d.second = s_q.first;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= {RESET_VAL, RESET_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.second;

endmodule

// ---- hdl/bsc_traffic_gate.sv ----
module bsc_traffic_gate (
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    input  wire bsc_pkg::bsc_mode_type    far_state_i,
    input  wire bsc_pkg::bsc_tlp_in_type  tlp_i,
    output bsc_pkg::bsc_tlp_out_type      tlp_o
);
    import bsc_pkg::*;

    typedef struct packed {
        bsc_tlp_out_type out;
    } bsc_gate_state_type;

    bsc_gate_state_type s_q;
    bsc_gate_state_type s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // classify each arriving transaction by the far side mode
    always_comb begin
        s_d            = s_q;
        s_d.out        = '0;
        s_d.out.credit = tlp_i.valid;
        case (far_state_i)
            BSC_ENABLED: begin
                s_d.out.accept = tlp_i.valid;
            end
            BSC_NOT_READY: begin
                s_d.out.retry   = tlp_i.valid & tlp_i.is_cfg;
                s_d.out.discard = tlp_i.valid & ~tlp_i.is_cfg;
            end
            BSC_DISABLED: begin
                s_d.out.discard = tlp_i.valid;
            end
            default: begin
                s_d.out.accept = tlp_i.valid;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tlp_o = s_q.out;

endmodule

// ---- hdl/bsc_side_control.sv ----
// What this block does
// - header bits 23:16 give capability length 0x40
// - header bits 31:24 hold type code 0x1
// - mode 0 enabled, 1 not ready, 3 reserved
// - not ready: config gets retry, rest ignored
// - disabled: far arrivals discarded, links keep running
// - credits returned for every discarded transaction
// - earlier non-enabled side returns to enabled
// - mode resets per side, only internal resets
// - guard bit 2 drops far writes silently
// - guarded far reads give zero except header
// - bit 3 enables action on far reset
// - action bits writable only on internal side
// - bit 4 picks which mode goes not ready
// - bit 5 propagates bridge reset pin while nt mode pin is high
// - writing one to bit 7 resets device
// - control bits reset zero, survive other resets
module bsc_side_control #(
    parameter logic INTERNAL_SIDE = 1'b1
) (
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      int_hot_reset_i,
    input  wire bsc_pkg::bsc_cfg_req_type  cfg_req_i,
    output bsc_pkg::bsc_cfg_rsp_type       cfg_rsp_o,
    input  wire bsc_pkg::bsc_mode_type     far_state_i,
    input  wire logic                      far_reset_detect_i,
    input  wire logic                      far_force_not_ready_i,
    input  wire bsc_pkg::bsc_tlp_in_type   far_tlp_i,
    output bsc_pkg::bsc_tlp_out_type       far_tlp_o,
    input  wire logic                      bridge_reset_pin_n_i,
    input  wire logic                      nt_mode_pin_i,
    output bsc_pkg::bsc_mode_type          far_side_state_o,
    output logic                           force_far_not_ready_o,
    output logic                           device_reset_o
);
    import bsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state of the block
    typedef struct packed {
        bsc_mode_type    far_side_state;
        logic            far_side_write_guard;
        logic            reset_action_enable;
        logic            reset_action_select;
        logic            propagate_pin_reset;
        logic [7:0]      vendor_specific_id;
        logic [7:0]      next_capability_pointer;
        logic [7:0]      capability_byte_length;
        logic [7:0]      vendor_capability_type;
        logic            far_busy_prev;
        logic            force_far;
        logic            dev_reset;
        bsc_cfg_rsp_type rsp;
    } bsc_ctl_state_type;

    // mode after reset depends on which side this instance serves
    localparam bsc_mode_type MODE_RST =
        INTERNAL_SIDE ? MODE_RST_INTERNAL : MODE_RST_EXTERNAL;

    localparam bsc_ctl_state_type STATE_RST = '{
        far_side_state:          MODE_RST,
        far_side_write_guard:    CTL_BIT_RST,
        reset_action_enable:     CTL_BIT_RST,
        reset_action_select:     CTL_BIT_RST,
        propagate_pin_reset:     CTL_BIT_RST,
        vendor_specific_id:      HDR_ID_RST,
        next_capability_pointer: HDR_NEXT_RST,
        capability_byte_length:  HDR_LEN_RST,
        vendor_capability_type:  HDR_TYPE_RST,
        far_busy_prev:           1'b0,
        force_far:               1'b0,
        dev_reset:               1'b0,
        rsp:                     '0
    };

    bsc_ctl_state_type s_q;
    bsc_ctl_state_type s_d;

    logic              pin_n_sync;
    logic              nt_mode_sync;
    logic              hit_hdr;
    logic              hit_ctl;
    logic              blocked;
    logic              far_busy_now;
    logic [31:0]       hdr_value;
    logic [7:0]        ctl_value;
    logic [7:0]        ctl_wbyte;

    ////////////////////////////////////////////////////////////////////////////////
    // pins from outside the clock domain
    bsc_sync #(
        .RESET_VAL (PIN_IDLE_LEVEL)
    ) u_pin_reset_sync (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .async_i   (bridge_reset_pin_n_i),
        .sync_o    (pin_n_sync)
    );

    bsc_sync #(
        .RESET_VAL (1'b0)
    ) u_nt_mode_sync (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .async_i   (nt_mode_pin_i),
        .sync_o    (nt_mode_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // traffic arriving on the far side, steered by the mode field
    bsc_traffic_gate u_gate (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .far_state_i (s_q.far_side_state),
        .tlp_i       (far_tlp_i),
        .tlp_o       (far_tlp_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // address decode and read views
    always_comb begin
        hit_hdr = cfg_req_i.valid && (cfg_req_i.addr[7:2] == CAP_HDR_OFFSET[7:2]);
        hit_ctl = cfg_req_i.valid && (cfg_req_i.addr[7:2] == CTRL_OFFSET[7:2]);
        // far requester locked out while the guard is set
        blocked = cfg_req_i.far_side && s_q.far_side_write_guard;
        far_busy_now = mode_busy(far_state_i);
        ctl_wbyte = cfg_req_i.wdata[7:0];
    end

    // header word as read back
    always_comb begin
        hdr_value = '0;
        hdr_value[HDR_ID_LSB +: 8]   = s_q.vendor_specific_id;
        hdr_value[HDR_NEXT_LSB +: 8] = s_q.next_capability_pointer;
        hdr_value[HDR_LEN_LSB +: 8]  = s_q.capability_byte_length;
        hdr_value[HDR_TYPE_LSB +: 8] = s_q.vendor_capability_type;
    end

    // control byte as read back, reset strobe always zero
    always_comb begin
        ctl_value = '0;
        ctl_value[CTL_MODE_LSB +: 2] = s_q.far_side_state;
        ctl_value[CTL_GUARD_BIT]     = s_q.far_side_write_guard;
        ctl_value[CTL_ACT_EN_BIT]    = s_q.reset_action_enable;
        ctl_value[CTL_RAS_BIT]       = s_q.reset_action_select;
        ctl_value[CTL_PIN_PROP_BIT]  = s_q.propagate_pin_reset;
        ctl_value[CTL_RST_BIT]       = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d           = s_q;
        s_d.rsp       = '0;
        s_d.force_far = 1'b0;
        s_d.dev_reset = 1'b0;

        // every request completes one cycle later
        if (cfg_req_i.valid) begin
            s_d.rsp.valid = 1'b1;
        end

        // reads; guarded far reads see only the header
        if (cfg_req_i.valid && !cfg_req_i.write) begin
            if (hit_hdr) begin
                s_d.rsp.rdata = hdr_value;
            end else if (hit_ctl && !blocked) begin
                s_d.rsp.rdata = {24'h000000, ctl_value};
            end
        end

        // header writes, byte lane by byte lane
        if (cfg_req_i.valid && cfg_req_i.write && hit_hdr && !blocked) begin
            if (cfg_req_i.be[0]) begin
                s_d.vendor_specific_id = cfg_req_i.wdata[HDR_ID_LSB +: 8];
            end
            if (cfg_req_i.be[1]) begin
                s_d.next_capability_pointer = cfg_req_i.wdata[HDR_NEXT_LSB +: 8];
            end
            if (cfg_req_i.be[2]) begin
                s_d.capability_byte_length = cfg_req_i.wdata[HDR_LEN_LSB +: 8];
            end
            if (cfg_req_i.be[3]) begin
                s_d.vendor_capability_type = cfg_req_i.wdata[HDR_TYPE_LSB +: 8];
            end
        end

        // control byte writes, lane 0 only
        if (cfg_req_i.valid && cfg_req_i.write && hit_ctl && !blocked
            && cfg_req_i.be[0]) begin
            case (bsc_mode_type'(ctl_wbyte[CTL_MODE_LSB +: 2]))
                BSC_ENABLED: begin
                    s_d.far_side_state = BSC_ENABLED;
                end
                BSC_NOT_READY: begin
                    s_d.far_side_state = BSC_NOT_READY;
                end
                BSC_DISABLED: begin
                    s_d.far_side_state = BSC_DISABLED;
                end
                default: begin
                    // reserved code leaves the mode as it was
                    s_d.far_side_state = s_q.far_side_state;
                end
            endcase
            s_d.far_side_write_guard = ctl_wbyte[CTL_GUARD_BIT];
            s_d.propagate_pin_reset  = ctl_wbyte[CTL_PIN_PROP_BIT];
            // action bits stay zero on the external side
            if (INTERNAL_SIDE) begin
                s_d.reset_action_enable = ctl_wbyte[CTL_ACT_EN_BIT];
                s_d.reset_action_select = ctl_wbyte[CTL_RAS_BIT];
            end
            s_d.dev_reset = ctl_wbyte[CTL_RST_BIT];
        end

        // bridge reset pin forwarded as a device reset
        if (!pin_n_sync && s_q.propagate_pin_reset && nt_mode_sync) begin
            s_d.dev_reset = 1'b1;
        end

        // action taken on a reset seen on the far side
        if (far_reset_detect_i && s_q.reset_action_enable) begin
            if (s_q.reset_action_select) begin
                s_d.far_side_state = BSC_NOT_READY;
            end else begin
                s_d.force_far = 1'b1;
            end
        end

        // far block asks this mode field to go not ready
        if (far_force_not_ready_i) begin
            s_d.far_side_state = BSC_NOT_READY;
        end

        // deadlock breaker: this side was busy first, so it yields
        if (mode_busy(s_q.far_side_state) && far_busy_now && !s_q.far_busy_prev) begin
            s_d.far_side_state = BSC_ENABLED;
        end
        s_d.far_busy_prev = far_busy_now;

        // internal hot reset restores the mode only
        if (int_hot_reset_i) begin
            s_d.far_side_state = MODE_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; rst_n_i is the internal fundamental reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign cfg_rsp_o             = s_q.rsp;
    assign far_side_state_o      = s_q.far_side_state;
    assign force_far_not_ready_o = s_q.force_far;
    assign device_reset_o        = s_q.dev_reset;

endmodule

// ---- tb/bsc_far_model.sv ----
module bsc_far_model
    import bsc_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  set_i,
    input  wire bsc_pkg::bsc_mode_type set_state_i,
    input  wire logic                  force_nr_i,
    input  wire bsc_pkg::bsc_mode_type near_state_i,
    output bsc_pkg::bsc_mode_type      state_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic near_busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // other side mode field, last action wins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_o     <= BSC_ENABLED;
            near_busy_q <= 1'b0;
        end else begin
            near_busy_q <= (near_state_i != BSC_ENABLED);
            if (set_i)
                state_o <= set_state_i;
            if (force_nr_i)
                state_o <= BSC_NOT_READY;
            // earlier busy side gives way on a new entry
            if (state_o != BSC_ENABLED && near_state_i != BSC_ENABLED && !near_busy_q)
                state_o <= BSC_ENABLED;
        end
    end
endmodule

// ---- tb/bsc_side_control_asserts.sv ----
module bsc_side_control_asserts
    import bsc_pkg::*;
#(
    parameter logic INTERNAL_SIDE = 1'b1
) (
    input wire logic                     clock_i,
    input wire logic                     rst_n_i,
    input wire logic                     int_hot_reset_i,
    input wire bsc_pkg::bsc_cfg_req_type cfg_req_i,
    input wire bsc_pkg::bsc_cfg_rsp_type cfg_rsp_o,
    input wire bsc_pkg::bsc_mode_type    far_state_i,
    input wire logic                     far_reset_detect_i,
    input wire logic                     far_force_not_ready_i,
    input wire bsc_pkg::bsc_tlp_in_type  far_tlp_i,
    input wire bsc_pkg::bsc_tlp_out_type far_tlp_o,
    input wire logic                     bridge_reset_pin_n_i,
    input wire logic                     nt_mode_pin_i,
    input wire bsc_pkg::bsc_mode_type    far_side_state_o,
    input wire logic                     force_far_not_ready_o,
    input wire logic                     device_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////////////
    // completions and far traffic disposition
    property p_rsp;
        cfg_req_i.valid |=> cfg_rsp_o.valid;
    endproperty
    a_rsp: assert property (p_rsp) else $error("request not completed");
    property p_nr;
        far_tlp_i.valid && far_side_state_o == BSC_NOT_READY
            |=> !far_tlp_o.accept && far_tlp_o.retry == $past(far_tlp_i.is_cfg);
    endproperty
    a_nr: assert property (p_nr) else $error("not ready handling wrong");
    property p_dis;
        far_tlp_i.valid && far_side_state_o == BSC_DISABLED
            |=> far_tlp_o.discard && !far_tlp_o.accept;
    endproperty
    a_dis: assert property (p_dis) else $error("disabled not discarding");
    property p_acc;
        far_tlp_i.valid && far_side_state_o == BSC_ENABLED
            |=> far_tlp_o.accept && !far_tlp_o.discard;
    endproperty
    a_acc: assert property (p_acc) else $error("enabled not accepting");
    property p_cred;
        far_tlp_i.valid |=> far_tlp_o.credit;
    endproperty
    a_cred: assert property (p_cred) else $error("credit missing");
    // control side effects
    property p_rst;
        cfg_req_i.valid && cfg_req_i.write && !cfg_req_i.far_side && cfg_req_i.be[0]
            && cfg_req_i.addr == CTRL_OFFSET && cfg_req_i.wdata[CTL_RST_BIT] |=> device_reset_o;
    endproperty
    a_rst: assert property (p_rst) else $error("device reset missing");
    property p_dl;
        far_side_state_o != BSC_ENABLED && far_state_i != BSC_ENABLED && !int_hot_reset_i
            && $past(far_state_i) == BSC_ENABLED |=> far_side_state_o == BSC_ENABLED;
    endproperty
    a_dl: assert property (p_dl) else $error("deadlock not resolved");
    property p_hot;
        int_hot_reset_i |=> far_side_state_o ==
            (INTERNAL_SIDE ? MODE_RST_INTERNAL : MODE_RST_EXTERNAL);
    endproperty
    a_hot: assert property (p_hot) else $error("hot reset mode wrong");

    c_retry: cover property (far_tlp_o.retry);
    c_force: cover property (force_far_not_ready_o);
    c_devrst: cover property (device_reset_o);
endmodule

bind bsc_side_control bsc_side_control_asserts #(.INTERNAL_SIDE(INTERNAL_SIDE)) u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .int_hot_reset_i(int_hot_reset_i),
    .cfg_req_i(cfg_req_i), .cfg_rsp_o(cfg_rsp_o), .far_state_i(far_state_i),
    .far_reset_detect_i(far_reset_detect_i), .far_force_not_ready_i(far_force_not_ready_i),
    .far_tlp_i(far_tlp_i), .far_tlp_o(far_tlp_o), .bridge_reset_pin_n_i(bridge_reset_pin_n_i),
    .nt_mode_pin_i(nt_mode_pin_i), .far_side_state_o(far_side_state_o),
    .force_far_not_ready_o(force_far_not_ready_o), .device_reset_o(device_reset_o)
);

// ---- tb/test_bridge_side_control.sv ----
module test_bridge_side_control;
    import bsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clock_i = 1'b0;
    logic            rst_n, hot, frd, ffr, pin_n, nt, set, force_o, dev_rst;
    bsc_cfg_req_type req;
    bsc_cfg_rsp_type rsp, rsp_x;
    bsc_tlp_in_type  tin;
    bsc_tlp_out_type tout;
    bsc_mode_type    far_st, st, st_x, set_st;
    logic [31:0]     r, x;
    int              mismatches = 0;
    int              checks_done = 0;

    always #4 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////////
    // internal side, external side and far model
    bsc_side_control #(.INTERNAL_SIDE(1'b1)) DUT (
        .clock_i(clock_i), .rst_n_i(rst_n), .int_hot_reset_i(hot), .cfg_req_i(req),
        .cfg_rsp_o(rsp), .far_state_i(far_st), .far_reset_detect_i(frd),
        .far_force_not_ready_i(ffr), .far_tlp_i(tin), .far_tlp_o(tout),
        .bridge_reset_pin_n_i(pin_n), .nt_mode_pin_i(nt), .far_side_state_o(st),
        .force_far_not_ready_o(force_o), .device_reset_o(dev_rst));
    bsc_side_control #(.INTERNAL_SIDE(1'b0)) DUT_EXT (
        .clock_i(clock_i), .rst_n_i(rst_n), .int_hot_reset_i(hot), .cfg_req_i(req),
        .cfg_rsp_o(rsp_x), .far_state_i(far_st), .far_reset_detect_i(frd),
        .far_force_not_ready_i(ffr), .far_tlp_i(tin), .far_tlp_o(),
        .bridge_reset_pin_n_i(pin_n), .nt_mode_pin_i(nt), .far_side_state_o(st_x),
        .force_far_not_ready_o(), .device_reset_o());
    bsc_far_model u_far (
        .clock_i(clock_i), .rst_n_i(rst_n), .set_i(set), .set_state_i(set_st),
        .force_nr_i(force_o), .near_state_i(st), .state_o(far_st));

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one request, completion looked at in its single cycle
    task automatic cfg(input logic w, input logic f, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        @(negedge clock_i);
        req = '{1'b1, w, f, a, be, d};
        @(negedge clock_i);
        req.valid = 1'b0;
        chk("rsp_valid", 32'h1, {31'h0, rsp.valid});
        r = rsp.rdata;
        x = rsp_x.rdata;
    endtask
    task automatic rdc(input string n, input logic f, input logic [7:0] a, input logic [31:0] e);
        cfg(1'b0, f, a, 4'hf, 32'h0);
        chk(n, e, r);
    endtask
    task automatic tlp(input logic c, input logic [3:0] e);
        @(negedge clock_i);
        tin = '{1'b1, c};
        @(negedge clock_i);
        tin.valid = 1'b0;
        chk("tlp_out", {28'h0, e}, {28'h0, tout});
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock_i);
        s = 1'b1;
        @(negedge clock_i);
        s = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rdc("hdr", 1'b0, CAP_HDR_OFFSET, 32'h0140b409);
        rdc("ctl", 1'b0, CTRL_OFFSET, 32'h1);
        chk("ctl_ext", 32'h0, x);
        rdc("unmapped", 1'b0, 8'h7c, 32'h0);
        cfg(1'b1, 1'b0, CAP_HDR_OFFSET, 4'hc, 32'h02300000);
        rdc("hdr_w", 1'b0, CAP_HDR_OFFSET, 32'h0230b409);
        cfg(1'b1, 1'b0, CAP_HDR_OFFSET, 4'hc, 32'h01400000);
        $display("done t_reset");
    endtask
    task automatic t_modes();
        logic [3:0] ec [3] = '{4'b1001, 4'b0101, 4'b0011};
        logic [3:0] en [3] = '{4'b1001, 4'b0011, 4'b0011};
        for (int m = 0; m < 3; m++) begin
            cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, m);
            rdc("mode", 1'b0, CTRL_OFFSET, m);
            tlp(1'b1, ec[m]);
            tlp(1'b0, en[m]);
        end
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h3);
        rdc("mode_rsvd", 1'b0, CTRL_OFFSET, 32'h2);
        $display("done t_modes");
    endtask
    task automatic t_guard();
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h04);
        cfg(1'b1, 1'b1, CTRL_OFFSET, 4'h1, 32'h01);
        cfg(1'b1, 1'b1, CAP_HDR_OFFSET, 4'hf, 32'h0);
        rdc("guard_w", 1'b0, CTRL_OFFSET, 32'h04);
        rdc("guard_wh", 1'b0, CAP_HDR_OFFSET, 32'h0140b409);
        rdc("guard_r", 1'b1, CTRL_OFFSET, 32'h0);
        rdc("guard_rh", 1'b1, CAP_HDR_OFFSET, 32'h0140b409);
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h0);
        cfg(1'b1, 1'b1, CTRL_OFFSET, 4'h1, 32'h02);
        rdc("open_w", 1'b0, CTRL_OFFSET, 32'h02);
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h0);
        $display("done t_guard");
    endtask
    task automatic t_far_reset();
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h18);
        rdc("action", 1'b0, CTRL_OFFSET, 32'h18);
        chk("action_ext", 32'h0, x);
        pulse(frd);
        rdc("ras1", 1'b0, CTRL_OFFSET, 32'h19);
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h08);
        pulse(frd);
        @(negedge clock_i);
        chk("ras0", BSC_NOT_READY, far_st);
        set_st = BSC_ENABLED;
        pulse(set);
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h0);
        pulse(ffr);
        rdc("forced", 1'b0, CTRL_OFFSET, 32'h01);
        $display("done t_far_reset");
    endtask
    task automatic t_deadlock();
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h02);
        set_st = BSC_NOT_READY;
        pulse(set);
        rdc("revert", 1'b0, CTRL_OFFSET, 32'h0);
        chk("far_kept", BSC_NOT_READY, far_st);
        set_st = BSC_ENABLED;
        pulse(set);
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h24);
        pulse(hot);
        rdc("hot", 1'b0, CTRL_OFFSET, 32'h25);
        $display("done t_deadlock");
    endtask
    task automatic t_pin();
        @(negedge clock_i);
        nt = 1'b0;
        pin_n = 1'b0;
        repeat (4) @(negedge clock_i);
        chk("pin_nt_off", 32'h0, {31'h0, dev_rst});
        nt = 1'b1;
        for (int i = 0; i < 8 && dev_rst !== 1'b1; i++) @(negedge clock_i);
        chk("pin_rst", 32'h1, {31'h0, dev_rst});
        pin_n = 1'b1;
        for (int i = 0; i < 8 && dev_rst !== 1'b0; i++) @(negedge clock_i);
        chk("pin_free", 32'h0, {31'h0, dev_rst});
        if (mismatches != 0) summarize();
        cfg(1'b1, 1'b0, CTRL_OFFSET, 4'h1, 32'h80);
        chk("soft_rst", 32'h1, {31'h0, dev_rst});
        rdc("rst_bit", 1'b0, CTRL_OFFSET, 32'h0);
        $display("done t_pin");
    endtask

    initial begin
        req = '0;
        tin = '0;
        {rst_n, hot, frd, ffr, set} = 5'h0;
        {pin_n, nt} = 2'h3;
        set_st = BSC_ENABLED;
        repeat (2) @(negedge clock_i);
        rst_n = 1'b1;
        t_reset();
        t_modes();
        t_guard();
        t_far_reset();
        t_deadlock();
        t_pin();
        summarize();
    end
endmodule
